// ==== src/core_state_pkg.sv ====
// Purpose: Shared types and constants for the core state and stack block
// Assumes: One core clock; sequencer and memories sit on the same clock
// Notes:   Saved return word is two bytes: flags/high PC, then low PC
package core_state_pkg;

  // Widths
  localparam int PC_W = 14;
  localparam int PAGE_W = 8;
  localparam int UPPER_W = PC_W - PAGE_W;
  localparam int BYTE_W = 8;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [BYTE_W-1:0] CALL_SP_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] DSP_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] ACC_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] OFS_RESET = 8'h00;

  // Field positions inside the first saved byte
  localparam int SAVE_CARRY_BIT = 7;
  localparam int SAVE_ZERO_BIT = 6;

  // Sequencer commands
  typedef enum logic [3:0] {
    OP_NONE,
    OP_STEP,       // Sequential advance by instruction length
    OP_PAGE_ADV,   // Page advance instruction
    OP_JUMP,       // Load PC from target
    OP_CALL,       // Subroutine call to target
    OP_INT_ACK,    // Interrupt acknowledge to target vector
    OP_RET,        // Plain subroutine return
    OP_INT_RET,    // Interrupt return instruction
    OP_PUSH,       // Data push of value
    OP_POP,        // Data pop into dest
    OP_LOAD_CALL_SP, // Load call stack pointer from accumulator
    OP_WRITE_REG,  // Write value into dest register
    OP_OPERAND,    // Fetch operand by mode
    OP_STORE,      // Store value at operand address
    OP_FLAGS,      // Update carry and zero
    OP_INT_EN      // Set interrupt enable to value bit 0
  } op_e;

  typedef enum logic [1:0] {
    MODE_DATA,
    MODE_DIRECT,
    MODE_INDEXED
  } mode_e;

  typedef enum logic [1:0] {
    DEST_ACC,
    DEST_OFS,
    DEST_OPERAND
  } dest_e;

  typedef struct packed {
    op_e op;
    logic two_byte;            // Instruction is two bytes long
    mode_e mode;
    dest_e dest;
    logic [BYTE_W-1:0] imm;    // Second instruction byte
    logic [BYTE_W-1:0] value;  // Data for writes and pushes
    logic [PC_W-1:0] target;   // Jump, call or vector address
    logic carry;
    logic zero;
  } cmd_s;

  typedef struct packed {
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
    logic we;
    logic re;
  } ram_req_s;

endpackage : core_state_pkg

// ==== src/core_state.sv ====
// Purpose: PC, accumulator, offset register, call and data stack pointers
// Assumes: SRAM returns read data in the cycle after the read strobe cycle
// Notes:   One command at a time; cmd_ready low while a sequence runs
//
// Overview of operation
// - Fourteen-bit PC clears on reset so first fetch is address zero.
// - Sequential steps move only low eight PC bits; page advance moves upper.
// - Instruction length is one or two bytes; PC steps by that length.
// - Call saves next PC, interrupt saves current PC, each with carry, zero as two stack bytes.
// - Carry and zero come back from stack only on interrupt return.
// - No firmware path to PC; saved bytes sit in SRAM from zero up.
// - Eight-bit accumulator is the general result destination.
// - Eight-bit offset register serves as second accumulator and index.
// - Call stack pointer clears on reset; stack grows upward from zero.
// - Firmware loads call stack pointer from accumulator by dedicated move.
// - Interrupt acknowledge disables interrupts, writes byte, bumps, writes, bumps.
// - Interrupt return decrements, restores second, decrements, restores first, enables.
// - Call pushes return address and flags, pointer ends two higher.
// - Plain return restores PC only, flags kept, pointer two lower.
// - Push pre-decrements data pointer then writes; pop reads then increments.
// - Data pointer resets to zero; push at zero stores at 0xff.
// - Data mode takes the constant from the second instruction byte.
// - Direct mode reads SRAM at the one-byte address in the instruction.
// - Indexed mode address is instruction constant plus offset register.
`timescale 1ns/1ns
module core_state
  import core_state_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  output logic cmd_ready,
  output logic done,
  output logic [PC_W-1:0] fetch_addr,
  output logic [BYTE_W-1:0] acc,
  output logic [BYTE_W-1:0] offset,
  output logic [BYTE_W-1:0] operand,
  output logic carry,
  output logic zero,
  output logic int_enable,
  output logic [BYTE_W-1:0] call_sp,
  output logic [BYTE_W-1:0] data_sp,
  output ram_req_s ram_req,
  input wire logic [BYTE_W-1:0] ram_rdata
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAVE2,
    ST_REST2,
    ST_REST1,
    ST_CAP2,
    ST_CAP1,
    ST_RDWAIT,
    ST_RDCAP
  } state_e;

  state_e state_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] jump_q;
  logic [BYTE_W-1:0] acc_q;
  logic [BYTE_W-1:0] ofs_q;
  logic [BYTE_W-1:0] operand_q;
  logic [BYTE_W-1:0] call_sp_q;
  logic [BYTE_W-1:0] dsp_q;
  logic [BYTE_W-1:0] byte2_q;
  logic [BYTE_W-1:0] save2_q;
  logic carry_q;
  logic zero_q;
  logic ie_q;
  logic int_ret_q;
  dest_e dest_q;
  ram_req_s ram_q;
  logic done_q;
  logic take;
  logic [PAGE_W-1:0] step_low;
  logic [PC_W-1:0] next_pc;
  logic [BYTE_W-1:0] op_addr;
  logic [BYTE_W-1:0] save1;

  ////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  assign cmd_ready = (state_q == ST_IDLE);
  assign take = cmd_valid && cmd_ready;

  // Low byte only; carry out of the page is dropped on purpose
  assign step_low = pc_q[PAGE_W-1:0]
                    + (cmd.two_byte ? 8'h02 : 8'h01);
  assign next_pc = {pc_q[PC_W-1:PAGE_W], step_low};

  // Operand address: direct or constant plus offset, 8-bit wrap
  assign op_addr = (cmd.mode == MODE_INDEXED)
                   ? cmd.imm + ofs_q
                   : cmd.imm;

  // First saved byte carries the flags above the upper PC bits
  always_comb begin
    save1 = {BYTE_W{1'b0}};
    save1[SAVE_CARRY_BIT] = carry_q;
    save1[SAVE_ZERO_BIT] = zero_q;
    save1[UPPER_W-1:0] = (cmd.op == OP_CALL)
                         ? next_pc[PC_W-1:PAGE_W]
                         : pc_q[PC_W-1:PAGE_W];
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence control

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            case (cmd.op)
              OP_CALL, OP_INT_ACK: state_q <= ST_SAVE2;
              OP_RET, OP_INT_RET: state_q <= ST_REST2;
              OP_POP: state_q <= ST_RDWAIT;
              OP_OPERAND: begin
                if (cmd.mode != MODE_DATA) begin
                  state_q <= ST_RDWAIT;
                end
              end
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_SAVE2: state_q <= ST_IDLE;
        ST_REST2: state_q <= ST_REST1;
        ST_REST1: state_q <= ST_CAP2;
        ST_CAP2: state_q <= ST_CAP1;
        ST_CAP1: state_q <= ST_IDLE;
        ST_RDWAIT: state_q <= ST_RDCAP;
        ST_RDCAP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Which kind of return is running, and where a read lands
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_ret_q <= 1'b0;
      dest_q <= DEST_ACC;
      jump_q <= PC_RESET;
      save2_q <= {BYTE_W{1'b0}};
    end else if (take) begin
      int_ret_q <= (cmd.op == OP_INT_RET);
      dest_q <= (cmd.op == OP_OPERAND) ? DEST_OPERAND : cmd.dest;
      jump_q <= cmd.target;
      save2_q <= (cmd.op == OP_CALL) ? next_pc[PAGE_W-1:0]
                                     : pc_q[PAGE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter; firmware has no read or write path to it

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= PC_RESET;
    end else if (take) begin
      case (cmd.op)
        OP_STEP: pc_q <= next_pc;
        OP_PAGE_ADV: begin
          // Upper bits increment only here
          pc_q[PC_W-1:PAGE_W] <= pc_q[PC_W-1:PAGE_W] + 6'h01;
          pc_q[PAGE_W-1:0] <= pc_q[PAGE_W-1:0] + 8'h01;
        end
        OP_JUMP: pc_q <= cmd.target;
        default: pc_q <= pc_q;
      endcase
    end else if (state_q == ST_SAVE2) begin
      pc_q <= jump_q;
    end else if (state_q == ST_CAP1) begin
      pc_q <= {ram_rdata[UPPER_W-1:0], byte2_q};
    end
  end

  assign fetch_addr = pc_q;

  ////////////////////////////////////////////////////////////////////////
  // Carry and zero flags

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (take && cmd.op == OP_FLAGS) begin
      carry_q <= cmd.carry;
      zero_q <= cmd.zero;
    end else if (state_q == ST_CAP1 && int_ret_q) begin
      // Plain return leaves the flags alone
      carry_q <= ram_rdata[SAVE_CARRY_BIT];
      zero_q <= ram_rdata[SAVE_ZERO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enable

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ie_q <= 1'b0;
    end else if (take && cmd.op == OP_INT_ACK) begin
      ie_q <= 1'b0;
    end else if (take && cmd.op == OP_INT_EN) begin
      ie_q <= cmd.value[0];
    end else if (state_q == ST_CAP1 && int_ret_q) begin
      // Only once both bytes are back
      ie_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Call stack pointer; 8-bit arithmetic wraps modulo 256

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      call_sp_q <= CALL_SP_RESET;
    end else if (take) begin
      case (cmd.op)
        OP_CALL, OP_INT_ACK: call_sp_q <= call_sp_q + 8'h01;
        OP_RET, OP_INT_RET: call_sp_q <= call_sp_q - 8'h01;
        OP_LOAD_CALL_SP: call_sp_q <= acc_q;
        default: call_sp_q <= call_sp_q;
      endcase
    end else if (state_q == ST_SAVE2) begin
      call_sp_q <= call_sp_q + 8'h01;
    end else if (state_q == ST_REST2) begin
      call_sp_q <= call_sp_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data stack pointer

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dsp_q <= DSP_RESET;
    end else if (take && cmd.op == OP_PUSH) begin
      dsp_q <= dsp_q - 8'h01;
    end else if (take && cmd.op == OP_POP) begin
      dsp_q <= dsp_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // SRAM request, registered so the memory sees clean strobes

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_q <= '0;
    end else begin
      ram_q.we <= 1'b0;
      ram_q.re <= 1'b0;
      if (take) begin
        case (cmd.op)
          OP_CALL, OP_INT_ACK: begin
            // First byte at the current pointer
            ram_q.addr <= call_sp_q;
            ram_q.wdata <= save1;
            ram_q.we <= 1'b1;
          end
          OP_PUSH: begin
            // Pre-decrement: zero pointer lands at 0xff
            ram_q.addr <= dsp_q - 8'h01;
            ram_q.wdata <= cmd.value;
            ram_q.we <= 1'b1;
          end
          OP_POP: begin
            ram_q.addr <= dsp_q;
            ram_q.re <= 1'b1;
          end
          OP_OPERAND: begin
            ram_q.addr <= op_addr;
            ram_q.re <= (cmd.mode != MODE_DATA);
          end
          OP_STORE: begin
            ram_q.addr <= op_addr;
            ram_q.wdata <= cmd.value;
            ram_q.we <= 1'b1;
          end
          default: ram_q.addr <= ram_q.addr;
        endcase
      end else if (state_q == ST_SAVE2) begin
        ram_q.addr <= call_sp_q;
        ram_q.wdata <= save2_q;
        ram_q.we <= 1'b1;
      end else if (state_q == ST_REST2 || state_q == ST_REST1) begin
        // Second byte read first, then the first byte
        ram_q.addr <= call_sp_q;
        ram_q.re <= 1'b1;
      end
    end
  end

  assign ram_req = ram_q;

  // Low PC byte held until the first byte arrives
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      byte2_q <= {BYTE_W{1'b0}};
    end else if (state_q == ST_CAP2) begin
      byte2_q <= ram_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator, offset register and operand

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= ACC_RESET;
      ofs_q <= OFS_RESET;
      operand_q <= {BYTE_W{1'b0}};
    end else if (take && cmd.op == OP_WRITE_REG) begin
      case (cmd.dest)
        DEST_ACC: acc_q <= cmd.value;
        DEST_OFS: ofs_q <= cmd.value;
        default: operand_q <= cmd.value;
      endcase
    end else if (take && cmd.op == OP_OPERAND
                 && cmd.mode == MODE_DATA) begin
      operand_q <= cmd.imm;
    end else if (state_q == ST_RDCAP) begin
      case (dest_q)
        DEST_ACC: acc_q <= ram_rdata;
        DEST_OFS: ofs_q <= ram_rdata;
        default: operand_q <= ram_rdata;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion pulse, registered on the same edge as the last state change

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (take && !(cmd.op inside {OP_CALL, OP_INT_ACK, OP_RET,
                                          OP_INT_RET, OP_POP})
                 && !(cmd.op == OP_OPERAND && cmd.mode != MODE_DATA))
                || state_q == ST_SAVE2
                || state_q == ST_CAP1
                || state_q == ST_RDCAP;
    end
  end

  assign done = done_q;
  assign acc = acc_q;
  assign offset = ofs_q;
  assign operand = operand_q;
  assign carry = carry_q;
  assign zero = zero_q;
  assign int_enable = ie_q;
  assign call_sp = call_sp_q;
  assign data_sp = dsp_q;

endmodule : core_state

// ==== verification/core_checker_assertions.sv ====
// Purpose: Port-level timing checks of the core state block
// Assumes: Command latencies of the core state sequencer
// Notes:   Bound into every core_state instance at the foot of this file
`timescale 1ns/1ns
module core_checker
  import core_state_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic [PC_W-1:0] fetch_addr,
  input wire logic [BYTE_W-1:0] acc,
  input wire logic [BYTE_W-1:0] offset,
  input wire logic carry,
  input wire logic zero,
  input wire logic int_enable,
  input wire logic [BYTE_W-1:0] call_sp,
  input wire logic [BYTE_W-1:0] data_sp,
  input wire ram_req_s ram_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic take;
  // Command accepted at this edge
  assign take = cmd_valid && cmd_ready;

  //////////////////////////////////////////////////////////////////////////
  // Results land at the take edge, so they are sampled one edge on;
  // strobes are one-cycle pulses and must be caught in that cycle
  a_reset_clears: assert property ($fell(sys_rst) |->
    fetch_addr == PC_RESET && call_sp == 8'h00 && data_sp == 8'h00)
    else $error("reset state wrong");
  a_step_low_only: assert property (take && cmd.op == OP_STEP |-> ##1
    fetch_addr[13:8] == ($past(fetch_addr) >> PAGE_W) && fetch_addr[7:0] ==
    8'($past(fetch_addr) + ($past(cmd.two_byte) ? 14'h0002 : 14'h0001)))
    else $error("step moved wrong pc bits");
  a_call_sp_two: assert property (take && cmd.op == OP_CALL |-> ##2
    done && call_sp == 8'($past(call_sp, 2) + 8'h02))
    else $error("call pointer not plus two");
  a_ack_disables: assert property (take && cmd.op == OP_INT_ACK |-> ##1
    (!int_enable && ram_req.we && ram_req.addr == $past(call_sp)) ##1
    (ram_req.we && ram_req.addr == 8'($past(call_sp, 2) + 8'h01)))
    else $error("acknowledge order wrong");
  a_int_return_late: assert property (take && cmd.op == OP_INT_RET |->
    ##1 (!done && $stable(int_enable))[*4] ##1 (done && int_enable))
    else $error("interrupt return enabled early");
  a_busy_refuses: assert property (take
    && cmd.op inside {OP_RET, OP_INT_RET} |-> ##1 (!cmd_ready)[*4]
    ##1 cmd_ready) else $error("ready wrong during return");
  a_ret_keeps_flags: assert property (take && cmd.op == OP_RET |-> ##5
    done && carry == $past(carry, 5) && zero == $past(zero, 5)
    && call_sp == 8'($past(call_sp, 5) - 8'h02)) else $error("return wrong");
  a_push_predec: assert property (take && cmd.op == OP_PUSH |-> ##1
    ram_req.we && ram_req.addr == 8'($past(data_sp) - 8'h01)
    && data_sp == ram_req.addr && ram_req.wdata == $past(cmd.value))
    else $error("push not pre-decremented");
  a_pop_postinc: assert property (take && cmd.op == OP_POP |-> ##1
    ram_req.re && ram_req.addr == $past(data_sp)
    && data_sp == 8'($past(data_sp) + 8'h01)) else $error("pop order wrong");
  a_load_pointer: assert property (take && cmd.op == OP_LOAD_CALL_SP
    |-> ##1 call_sp == $past(acc)) else $error("pointer load wrong");
  a_indexed_addr: assert property (take && cmd.op == OP_OPERAND
    && cmd.mode == MODE_INDEXED |-> ##1 ram_req.re
    && ram_req.addr == 8'($past(cmd.imm) + $past(offset)))
    else $error("indexed address wrong");

  // Main scenarios reached
  c_int_return: cover property (take && cmd.op == OP_INT_RET);
  c_ack: cover property (take && cmd.op == OP_INT_ACK);
  c_push_wrap: cover property (take && cmd.op == OP_PUSH && data_sp == 8'h00);
endmodule : core_checker

bind core_state core_checker chk (.mclk, .sys_rst, .cmd_valid, .cmd,
  .cmd_ready, .done, .fetch_addr, .acc, .offset, .carry, .zero, .int_enable,
  .call_sp, .data_sp, .ram_req);

// ==== verification/sram_model.sv ====
// Purpose: Behavioural data SRAM facing the core state block
// Assumes: Read data is due in the cycle after the read strobe
// Notes:   Fixed latency only; the block has no wait input to stall it
`timescale 1ns/1ns
module sram_model
  import core_state_pkg::*;
(
  input wire logic mclk,
  input wire ram_req_s ram_req,
  output logic [BYTE_W-1:0] ram_rdata
);
  logic [BYTE_W-1:0] mem [256];

  // Known contents so the bench can inspect saved bytes
  initial begin
    ram_rdata = 8'h00;
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // Bus toggles outside the read slot so stale data is never mistaken
  always @(posedge mclk) begin
    if (ram_req.we) begin
      mem[ram_req.addr] <= ram_req.wdata;
    end
    if (ram_req.re) begin
      ram_rdata <= mem[ram_req.addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule : sram_model

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the core state block
// Assumes: One command in flight; done marks completion
// Notes:   Saved bytes are read straight out of the SRAM model
`timescale 1ns/1ns
module testbench
  import core_state_pkg::*;
;
  logic mclk, sys_rst, cmd_valid, cmd_ready, done, carry, zero, int_enable;
  cmd_s cmd, c;
  logic [PC_W-1:0] fetch_addr;
  logic [BYTE_W-1:0] acc, offset, operand, call_sp, data_sp, ram_rdata;
  ram_req_s ram_req;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  core_state dut (.mclk, .sys_rst, .cmd_valid, .cmd, .cmd_ready, .done,
    .fetch_addr, .acc, .offset, .operand, .carry, .zero, .int_enable,
    .call_sp, .data_sp, .ram_req, .ram_rdata);
  sram_model sram (.mclk, .ram_req, .ram_rdata);

  // 50 ns core clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Hang guard, far above the roughly 120 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic cmd_s mk(op_e op, logic [7:0] v, logic [PC_W-1:0] t);
    cmd_s r;
    r = '0;
    r.op = op;
    r.value = v;
    r.target = t;
    return r;
  endfunction : mk

  // Issue one command and wait, bounded, for its done pulse
  task automatic go(input cmd_s x);
    int n;
    n = 0;
    @(posedge mclk);
    cmd <= x;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("done", 16'(n < 20), 16'h0001);
    // One more edge so the SRAM has taken the last write of the command
    @(posedge mclk);
    #1;
  endtask : go

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("pc", 16'(fetch_addr), 16'h0000);
    check("call_sp", 16'(call_sp), 16'h0000);
    check("data_sp", 16'(data_sp), 16'h0000);
    $display("t_reset finished");
  endtask : t_reset

  // Low byte wraps inside the page; only the page advance moves upper bits
  task automatic t_pc;
    go(mk(OP_JUMP, 8'h00, 14'h01fe));
    c = mk(OP_STEP, 8'h00, 14'h0000);
    c.two_byte = 1'b1;
    go(c);
    check("pc", 16'(fetch_addr), 16'h0100);
    go(mk(OP_STEP, 8'h00, 14'h0000));
    check("pc", 16'(fetch_addr), 16'h0101);
    go(mk(OP_PAGE_ADV, 8'h00, 14'h0000));
    check("pc", 16'(fetch_addr), 16'h0202);
    $display("t_pc finished");
  endtask : t_pc

  task automatic t_operand;
    go(mk(OP_WRITE_REG, 8'h5a, 14'h0000));
    check("acc", 16'(acc), 16'h005a);
    c = mk(OP_WRITE_REG, 8'h03, 14'h0000);
    c.dest = DEST_OFS;
    go(c);
    check("offset", 16'(offset), 16'h0003);
    c = mk(OP_OPERAND, 8'h00, 14'h0000);
    c.imm = 8'he8;
    go(c);
    check("operand", 16'(operand), 16'h00e8);
    c = mk(OP_STORE, 8'h77, 14'h0000);
    c.mode = MODE_DIRECT;
    c.imm = 8'h10;
    go(c);
    c.mode = MODE_INDEXED;
    c.value = 8'h99;
    go(c);
    check("mem13", 16'(sram.mem[8'h13]), 16'h0099);
    c = mk(OP_OPERAND, 8'h00, 14'h0000);
    c.mode = MODE_DIRECT;
    c.imm = 8'h10;
    go(c);
    check("operand", 16'(operand), 16'h0077);
    c.mode = MODE_INDEXED;
    go(c);
    check("operand", 16'(operand), 16'h0099);
    $display("t_operand finished");
  endtask : t_operand

  // Call saves next pc and flags; plain return leaves flags alone
  task automatic t_call_ret;
    go(mk(OP_JUMP, 8'h00, 14'h1234));
    c = mk(OP_FLAGS, 8'h00, 14'h0000);
    c.carry = 1'b1;
    go(c);
    c = mk(OP_CALL, 8'h00, 14'h0abc);
    c.two_byte = 1'b1;
    go(c);
    check("pc", 16'(fetch_addr), 16'h0abc);
    check("call_sp", 16'(call_sp), 16'h0002);
    check("mem0", 16'(sram.mem[8'h00]), 16'h0092);
    check("mem1", 16'(sram.mem[8'h01]), 16'h0036);
    c = mk(OP_FLAGS, 8'h00, 14'h0000);
    c.zero = 1'b1;
    go(c);
    go(mk(OP_RET, 8'h00, 14'h0000));
    check("pc", 16'(fetch_addr), 16'h1236);
    check("call_sp", 16'(call_sp), 16'h0000);
    check("flags", 16'({carry, zero}), 16'h0001);
    $display("t_call_ret finished");
  endtask : t_call_ret

  task automatic t_interrupt;
    go(mk(OP_INT_EN, 8'h01, 14'h0000));
    c = mk(OP_FLAGS, 8'h00, 14'h0000);
    c.carry = 1'b1;
    c.zero = 1'b1;
    go(c);
    go(mk(OP_INT_ACK, 8'h00, 14'h0004));
    check("int_enable", 16'(int_enable), 16'h0000);
    check("pc", 16'(fetch_addr), 16'h0004);
    check("mem0", 16'(sram.mem[8'h00]), 16'h00d2);
    check("mem1", 16'(sram.mem[8'h01]), 16'h0036);
    go(mk(OP_FLAGS, 8'h00, 14'h0000));
    go(mk(OP_INT_RET, 8'h00, 14'h0000));
    check("pc", 16'(fetch_addr), 16'h1236);
    check("flags", 16'({carry, zero}), 16'h0003);
    check("int_enable", 16'(int_enable), 16'h0001);
    check("call_sp", 16'(call_sp), 16'h0000);
    $display("t_interrupt finished");
  endtask : t_interrupt

  // Pointer loaded to the top of RAM so the saved pair straddles the wrap
  task automatic t_call_sp_wrap;
    go(mk(OP_WRITE_REG, 8'hff, 14'h0000));
    go(mk(OP_LOAD_CALL_SP, 8'h00, 14'h0000));
    check("call_sp", 16'(call_sp), 16'h00ff);
    go(mk(OP_CALL, 8'h00, 14'h0040));
    check("memff", 16'(sram.mem[8'hff]), 16'h00d2);
    check("mem0", 16'(sram.mem[8'h00]), 16'h0037);
    check("call_sp", 16'(call_sp), 16'h0001);
    go(mk(OP_RET, 8'h00, 14'h0000));
    check("call_sp", 16'(call_sp), 16'h00ff);
    check("pc", 16'(fetch_addr), 16'h1237);
    $display("t_call_sp_wrap finished");
  endtask : t_call_sp_wrap

  task automatic t_data_stack;
    go(mk(OP_PUSH, 8'ha5, 14'h0000));
    check("memff", 16'(sram.mem[8'hff]), 16'h00a5);
    check("data_sp", 16'(data_sp), 16'h00ff);
    go(mk(OP_PUSH, 8'h3c, 14'h0000));
    check("memfe", 16'(sram.mem[8'hfe]), 16'h003c);
    go(mk(OP_POP, 8'h00, 14'h0000));
    check("acc", 16'(acc), 16'h003c);
    c = mk(OP_POP, 8'h00, 14'h0000);
    c.dest = DEST_OFS;
    go(c);
    check("offset", 16'(offset), 16'h00a5);
    check("data_sp", 16'(data_sp), 16'h0000);
    $display("t_data_stack finished");
  endtask : t_data_stack

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    c = '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_pc();
    t_operand();
    t_call_ret();
    t_interrupt();
    t_call_sp_wrap();
    t_data_stack();
    stop_test();
  end
endmodule : testbench
